// >>> verilog/sid_top.sv
// Purpose: Front-panel status indicator driver with AHB-Lite registers.
// Assumes: Status inputs synchronous to CLK_SYS; one OKAY slave.
// Notes: Two-bit LED codes: 0 off, 1 green, 2 yellow, 3 red.
`timescale 1ns/10ps
`default_nettype none
`include "sid_defs.svh"
module sid_top #(
    parameter int NCH = `SID_NCH,
    parameter int BLINK_HALF_CYC = `SID_BLINK_CYC
) (
    input wire logic CLK_SYS,
    input wire logic RST_N,
    input wire logic HSEL,
    input wire logic [31:0] HADDR,
    input wire logic [1:0] HTRANS,
    input wire logic HWRITE,
    input wire logic [2:0] HSIZE,
    input wire logic [31:0] HWDATA,
    input wire logic HREADY,
    output logic [31:0] HRDATA,
    output logic HREADYOUT,
    output logic HRESP,
    input wire sid_pkg::sid_port_s PORT_STAT,
    input wire sid_pkg::sid_supply_s SUPPLY_STAT,
    input wire sid_pkg::sid_net_s NET_STAT,
    input wire logic [NCH-1:0] CH_IN,
    input wire logic [NCH-1:0] CH_FAULT,
    output logic [1:0] PORT_LINK_LED,
    output logic [1:0] PORT_ACTIVITY_LED,
    output logic [1:0] RDY_LED,
    output logic [1:0] NET_LED,
    output logic [1:0] MOD_LED,
    output logic [1:0] SENSOR_SUPPLY_LED,
    output logic ACTUATOR_SUPPLY_LED,
    output logic [2*NCH-1:0] IO_CHANNELS,
    output logic [NCH-1:0] CH_OUT,
    output logic IP_SUPPRESS
);
    import sid_pkg::*;

    if (NCH < 1 || NCH > 32) begin : g_bad_nch
        $error("NCH must lie between 1 and 32.");
    end
    if (BLINK_HALF_CYC < 1) begin : g_bad_blink
        $error("BLINK_HALF_CYC must be at least one.");
    end

    // Bus slave state.
    logic [31:0] ctrl_q;
    logic [31:0] safe_q;
    logic [31:0] dir_q;
    logic [31:0] out_q;
    logic wr_pend_q;
    logic [7:0] wr_addr_q;
    logic [31:0] rdata_q;
    logic blink;
    logic timeout_seen_q;

    function automatic logic is_addr(input logic [31:0] a, input logic [7:0] off);
        is_addr = (a[7:0] == off) && (a[31:8] == 24'h00_0000);
    endfunction

    function automatic logic [1:0] flash(input logic ph, input logic [1:0] on_c, input logic [1:0] off_c);
        flash = ph ? on_c : off_c;
    endfunction

    logic take;
    assign take = HSEL && HREADY && HTRANS[1];
    assign HREADYOUT = 1'b1;
    assign HRESP = 1'b0;

    always_ff @(posedge CLK_SYS or negedge RST_N) begin
        if (!RST_N) begin
            wr_pend_q <= 1'b0;
            wr_addr_q <= 8'h00;
        end else begin
            wr_pend_q <= take && HWRITE && (HADDR[31:8] == 24'h00_0000);
            wr_addr_q <= HADDR[7:0];
        end
    end

    always_ff @(posedge CLK_SYS or negedge RST_N) begin
        if (!RST_N) begin
            ctrl_q <= `SID_CTRL_RST;
            safe_q <= `SID_SAFE_RST;
            dir_q <= `SID_DIR_RST;
            out_q <= `SID_OUT_RST;
        end else if (wr_pend_q) begin
            case (wr_addr_q)
                `SID_ADDR_CTRL: begin
                    ctrl_q <= HWDATA;
                end
                `SID_ADDR_SAFE: begin
                    safe_q <= HWDATA;
                end
                `SID_ADDR_DIR: begin
                    dir_q <= HWDATA;
                end
                `SID_ADDR_OUT: begin
                    out_q <= HWDATA;
                end
                default: begin
                end
            endcase
        end
    end

    logic [31:0] stat_word;
    logic [31:0] led_word;
    assign stat_word = {20'h0_0000, 4'(PORT_STAT), timeout_seen_q, 7'(NET_STAT)};

    always_ff @(posedge CLK_SYS or negedge RST_N) begin
        if (!RST_N) begin
            rdata_q <= 32'h0000_0000;
        end else if (take && !HWRITE) begin
            if (is_addr(HADDR, `SID_ADDR_CTRL)) begin
                rdata_q <= ctrl_q;
            end else if (is_addr(HADDR, `SID_ADDR_SAFE)) begin
                rdata_q <= safe_q;
            end else if (is_addr(HADDR, `SID_ADDR_DIR)) begin
                rdata_q <= dir_q;
            end else if (is_addr(HADDR, `SID_ADDR_OUT)) begin
                rdata_q <= out_q;
            end else if (is_addr(HADDR, `SID_ADDR_STAT)) begin
                rdata_q <= stat_word;
            end else if (is_addr(HADDR, `SID_ADDR_LEDS)) begin
                rdata_q <= led_word;
            end else begin
                rdata_q <= 32'h0000_0000;
            end
        end
    end
    assign HRDATA = rdata_q;

    // Control bits.
    logic ready;
    logic fw_update;
    logic self_test;
    logic configured;
    logic rec_err;
    logic unrec_err;
    assign ready = ctrl_q[`SID_CTRL_RDY_BIT];
    assign fw_update = ctrl_q[`SID_CTRL_FWU_BIT];
    assign self_test = ctrl_q[`SID_CTRL_SELF_BIT];
    assign configured = ctrl_q[`SID_CTRL_CFG_BIT];
    assign rec_err = ctrl_q[`SID_CTRL_RERR_BIT];
    assign unrec_err = ctrl_q[`SID_CTRL_UERR_BIT];

    sid_blink #(
        .HALF_CYC(BLINK_HALF_CYC)
    ) u_blink (
        .clk(CLK_SYS),
        .rst_n(RST_N),
        .phase(blink)
    );

    // Timeout latches until the next connection is made.
    always_ff @(posedge CLK_SYS or negedge RST_N) begin
        if (!RST_N) begin
            timeout_seen_q <= 1'b0;
        end else if (NET_STAT.eo_timeout) begin
            timeout_seen_q <= 1'b1;
        end else if (NET_STAT.conn_any) begin
            timeout_seen_q <= 1'b0;
        end
    end

    logic [1:0] rdy_d;
    logic [1:0] net_d;
    logic [1:0] mod_d;
    logic [1:0] us_d;
    logic [2*NCH-1:0] ch_led_d;
    logic [NCH-1:0] ch_out_d;
    logic ip_sup_d;
    logic supply_fault;
    logic timed_out;
    assign supply_fault = SUPPLY_STAT.us_bad_volt || SUPPLY_STAT.temp_crit || SUPPLY_STAT.us_overload;
    assign timed_out = NET_STAT.eo_timeout || timeout_seen_q;

    always_comb begin
        rdy_d = SID_OFF;
        if (ready) begin
            if (SUPPLY_STAT.sw_invalid) begin
                rdy_d = SID_RED;
            end else if (supply_fault) begin
                rdy_d = flash(blink, SID_YEL, SID_GRN);
            end else if (fw_update) begin
                rdy_d = flash(blink, SID_YEL, SID_OFF);
            end else begin
                rdy_d = SID_GRN;
            end
        end
    end

    always_comb begin
        net_d = SID_OFF;
        ip_sup_d = NET_STAT.acd_conflict && NET_STAT.manual_addr;
        if (ready) begin
            if (self_test) begin
                net_d = flash(blink, SID_RED, SID_GRN);
            end else if (NET_STAT.acd_conflict) begin
                net_d = SID_RED;
            end else if (timed_out) begin
                net_d = flash(blink, SID_RED, SID_OFF);
            end else if (NET_STAT.conn_any) begin
                net_d = SID_GRN;
            end else if (NET_STAT.ip_cfg) begin
                net_d = flash(blink, SID_GRN, SID_OFF);
            end
        end
    end

    always_comb begin
        mod_d = SID_OFF;
        if (ready) begin
            if (self_test) begin
                mod_d = flash(blink, SID_RED, SID_GRN);
            end else if (unrec_err) begin
                mod_d = flash(blink, SID_RED, SID_OFF);
            end else if (rec_err) begin
                mod_d = SID_RED;
            end else if (!configured) begin
                mod_d = flash(blink, SID_GRN, SID_OFF);
            end else begin
                mod_d = SID_GRN;
            end
        end
    end

    always_comb begin
        if (SUPPLY_STAT.us_overload) begin
            us_d = SID_RED;
        end else if (SUPPLY_STAT.us_ok) begin
            us_d = SID_GRN;
        end else begin
            us_d = SID_OFF;
        end
    end

    // Bit b of byte k drives LED pair at index 8*k+b.
    genvar gi;
    generate
        for (gi = 0; gi < NCH; gi++) begin : g_ch
            always_comb begin
                ch_out_d[gi] = timed_out ? safe_q[gi] : out_q[gi];
                if (!dir_q[gi]) begin
                    ch_led_d[2*gi+1:2*gi] = CH_IN[gi] ? SID_YEL : SID_OFF;
                end else if (CH_FAULT[gi]) begin
                    ch_led_d[2*gi+1:2*gi] = SID_RED;
                end else begin
                    ch_led_d[2*gi+1:2*gi] = ch_out_d[gi] ? SID_YEL : SID_OFF;
                end
            end
        end
    endgenerate

    always_ff @(posedge CLK_SYS or negedge RST_N) begin
        if (!RST_N) begin
            PORT_LINK_LED <= 2'h0;
            PORT_ACTIVITY_LED <= 2'h0;
            ACTUATOR_SUPPLY_LED <= 1'b0;
        end else begin
            PORT_LINK_LED <= PORT_STAT.link;
            PORT_ACTIVITY_LED <= PORT_STAT.act;
            ACTUATOR_SUPPLY_LED <= SUPPLY_STAT.ua_ok;
        end
    end

    always_ff @(posedge CLK_SYS or negedge RST_N) begin
        if (!RST_N) begin
            SENSOR_SUPPLY_LED <= 2'h0;
        end else begin
            SENSOR_SUPPLY_LED <= us_d;
        end
    end

    always_ff @(posedge CLK_SYS or negedge RST_N) begin
        if (!RST_N) begin
            RDY_LED <= 2'h0;
            NET_LED <= 2'h0;
            MOD_LED <= 2'h0;
        end else begin
            RDY_LED <= rdy_d;
            NET_LED <= net_d;
            MOD_LED <= mod_d;
        end
    end

    always_ff @(posedge CLK_SYS or negedge RST_N) begin
        if (!RST_N) begin
            IP_SUPPRESS <= 1'b0;
        end else begin
            IP_SUPPRESS <= ip_sup_d;
        end
    end

    always_ff @(posedge CLK_SYS or negedge RST_N) begin
        if (!RST_N) begin
            IO_CHANNELS <= '0;
        end else begin
            IO_CHANNELS <= ch_led_d;
        end
    end

    always_ff @(posedge CLK_SYS or negedge RST_N) begin
        if (!RST_N) begin
            CH_OUT <= '0;
        end else begin
            CH_OUT <= ch_out_d;
        end
    end

    assign led_word = {16'h0000, 2'h0, ACTUATOR_SUPPLY_LED, 1'b0, SENSOR_SUPPLY_LED, MOD_LED, NET_LED,
                       RDY_LED, PORT_ACTIVITY_LED, PORT_LINK_LED};
endmodule
`default_nettype wire

// >>> verilog/sid_defs.svh
// Purpose: Constants of the status indicator driver.
// Assumes: Included by the package and by sid_top; sid_blink does not include it.
// Notes: Offsets, fields, reset values and timing counts.
`ifndef SID_DEFS_SVH
`define SID_DEFS_SVH
`define SID_CLK_MHZ 200
`define SID_BLINK_MS 250
`define SID_BLINK_CYC (`SID_BLINK_MS * 1000 * `SID_CLK_MHZ)
`define SID_NCH 16
`define SID_ADDR_CTRL 8'h00
`define SID_ADDR_SAFE 8'h04
`define SID_ADDR_DIR 8'h08
`define SID_ADDR_OUT 8'h0C
`define SID_ADDR_STAT 8'h10
`define SID_ADDR_LEDS 8'h14
`define SID_CTRL_RDY_BIT 0
`define SID_CTRL_FWU_BIT 1
`define SID_CTRL_SELF_BIT 2
`define SID_CTRL_CFG_BIT 3
`define SID_CTRL_RERR_BIT 4
`define SID_CTRL_UERR_BIT 5
`define SID_CTRL_RST 32'h0000_0000
`define SID_SAFE_RST 32'h0000_0000
`define SID_DIR_RST 32'h0000_0000
`define SID_OUT_RST 32'h0000_0000
`endif

// >>> verilog/sid_pkg.sv
// Purpose: Types of the status indicator driver.
// Assumes: sid_defs.svh holds the numbers.
// Notes: LED colours and status carriers.
`include "sid_defs.svh"
package sid_pkg;
    typedef enum logic [1:0] {
        SID_OFF = 2'b00,
        SID_GRN = 2'b01,
        SID_YEL = 2'b10,
        SID_RED = 2'b11
    } sid_color_e;
    typedef struct packed {
        logic [1:0] link;
        logic [1:0] act;
    } sid_port_s;
    typedef struct packed {
        logic us_ok;
        logic us_bad_volt;
        logic us_overload;
        logic ua_ok;
        logic temp_crit;
        logic sw_invalid;
    } sid_supply_s;
    typedef struct packed {
        logic conn_any;
        logic eo_timeout;
        logic ip_cfg;
        logic acd_conflict;
        logic manual_addr;
    } sid_net_s;
endpackage

// >>> verilog/sid_blink.sv
// Purpose: Common blink phase for all flashing patterns.
// Assumes: One clock, asynchronous active-low reset.
// Notes: Phase toggles every HALF_CYC cycles.
`timescale 1ns/10ps
`default_nettype none
module sid_blink #(
    parameter int HALF_CYC = 1000
) (
    input wire logic clk,
    input wire logic rst_n,
    output logic phase
);
    logic [31:0] cnt_q;
    logic phase_q;
    if (HALF_CYC < 1) begin : g_bad_half
        $error("HALF_CYC must be at least one.");
    end
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_q <= 32'h0000_0000;
            phase_q <= 1'b0;
        end else if (cnt_q >= 32'(HALF_CYC - 1)) begin
            cnt_q <= 32'h0000_0000;
            phase_q <= ~phase_q;
        end else begin
            cnt_q <= cnt_q + 32'h0000_0001;
        end
    end
    assign phase = phase_q;
endmodule
`default_nettype wire

// >>> verification/sid_chk.sv
// Purpose: Port assertions for the status indicator driver.
// Assumes: Bound to sid_top; LED outputs lag their status inputs by one edge.
// Notes: Register-dependent states are left to the testbench.
`timescale 1ns/10ps
`default_nettype none
module sid_chk #(
    parameter int NCH = 16
) (
    input wire logic CLK_SYS,
    input wire logic RST_N,
    input wire sid_pkg::sid_port_s PORT_STAT,
    input wire sid_pkg::sid_supply_s SUPPLY_STAT,
    input wire sid_pkg::sid_net_s NET_STAT,
    input wire logic [NCH-1:0] CH_FAULT,
    input wire logic [1:0] PORT_LINK_LED,
    input wire logic [1:0] PORT_ACTIVITY_LED,
    input wire logic [1:0] RDY_LED,
    input wire logic [1:0] SENSOR_SUPPLY_LED,
    input wire logic ACTUATOR_SUPPLY_LED,
    input wire logic [2*NCH-1:0] IO_CHANNELS,
    input wire logic IP_SUPPRESS
);
    import sid_pkg::*;
    logic [NCH-1:0] red_m;
    always_comb begin
        for (int i = 0; i < NCH; i++) begin
            red_m[i] = (IO_CHANNELS[2*i+:2] == 2'h3);
        end
    end
    default clocking cb @(posedge CLK_SYS); endclocking
    default disable iff (!RST_N);
    link_follow_a: assert property (1'b1 |=> PORT_LINK_LED == $past(PORT_STAT.link))
        else $error("link LED does not follow link state");
    act_follow_a: assert property ($changed(PORT_STAT.act) |=> PORT_ACTIVITY_LED == $past(PORT_STAT.act))
        else $error("activity LED does not follow activity");
    ua_follow_a: assert property (1'b1 |=> ACTUATOR_SUPPLY_LED == $past(SUPPLY_STAT.ua_ok))
        else $error("actuator supply LED wrong");
    us_red_a: assert property (SUPPLY_STAT.us_overload |=> SENSOR_SUPPLY_LED == SID_RED)
        else $error("sensor supply LED not red on overload");
    us_dark_a: assert property (!SUPPLY_STAT.us_ok && !SUPPLY_STAT.us_overload |=> SENSOR_SUPPLY_LED == SID_OFF)
        else $error("sensor supply LED lit without supply");
    rdy_red_a: assert property (RDY_LED == SID_RED |-> $past(SUPPLY_STAT.sw_invalid))
        else $error("ready LED red without invalid switch");
    ip_drop_a: assert property (1'b1 |=> IP_SUPPRESS == $past(NET_STAT.acd_conflict && NET_STAT.manual_addr))
        else $error("address suppression wrong");
    ch_red_a: assert property (1'b1 |=> (red_m & ~$past(CH_FAULT)) == '0)
        else $error("channel LED red without fault");
    cover property (SENSOR_SUPPLY_LED == SID_RED);
    cover property (RDY_LED == SID_RED);
    cover property (IP_SUPPRESS);
endmodule
bind sid_top sid_chk #(.NCH(NCH)) i_sid_chk (.CLK_SYS(CLK_SYS), .RST_N(RST_N), .PORT_STAT(PORT_STAT),
    .SUPPLY_STAT(SUPPLY_STAT), .NET_STAT(NET_STAT), .CH_FAULT(CH_FAULT), .PORT_LINK_LED(PORT_LINK_LED),
    .PORT_ACTIVITY_LED(PORT_ACTIVITY_LED), .RDY_LED(RDY_LED), .SENSOR_SUPPLY_LED(SENSOR_SUPPLY_LED),
    .ACTUATOR_SUPPLY_LED(ACTUATOR_SUPPLY_LED), .IO_CHANNELS(IO_CHANNELS), .IP_SUPPRESS(IP_SUPPRESS));
`default_nettype wire

// >>> verification/sid_panel.sv
// Purpose: Operator view of one front-panel LED.
// Assumes: Two-bit colour code; clr restarts the observation.
// Notes: Bit k of seen is set once colour k has been shown.
`timescale 1ns/10ps
`default_nettype none
module sid_panel (
    input wire logic clk,
    input wire logic clr,
    input wire logic [1:0] led,
    output logic [3:0] seen
);
    always @(posedge clk) begin
        if (clr) begin
            seen <= 4'h0;
        end else begin
            seen <= seen | (4'h1 << led);
        end
    end
endmodule
`default_nettype wire

// >>> verification/sid_top_tb_top.sv
// Purpose: Self-checking bench for the status indicator driver.
// Assumes: Short blink period; zero-wait AHB-Lite slave.
// Notes: Flash patterns are judged by the set of colours seen.
`timescale 1ns/10ps
`default_nettype none
module sid_top_tb_top;
    import sid_pkg::*;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [2:0] hsize = 3'h0;
    logic [31:0] hwdata = 32'h0;
    wire logic [31:0] hrdata;
    wire logic hreadyout;
    sid_port_s port_stat = '0;
    sid_supply_s sup = '0;
    sid_net_s net = '0;
    logic [15:0] ch_in = 16'h0;
    logic [15:0] ch_fault = 16'h0;
    logic clr = 1'b1;
    wire logic [1:0] link_led, act_led, rdy_led, net_led, mod_led, us_led;
    wire logic ua_led, ip_sup;
    wire logic [31:0] io_ch;
    wire logic [15:0] ch_out;
    wire logic [3:0] seen [4];
    int bad_count = 0;
    int checked = 0;
    logic [31:0] rd;
    logic [1:0] e;
    logic [34:0] tbl [16];
    sid_top #(.NCH(16), .BLINK_HALF_CYC(4)) i_sid_top (.CLK_SYS(clk), .RST_N(rst_n), .HSEL(hsel),
        .HADDR(haddr), .HTRANS(htrans), .HWRITE(hwrite), .HSIZE(hsize), .HWDATA(hwdata), .HREADY(hreadyout),
        .HRDATA(hrdata), .HREADYOUT(hreadyout), .HRESP(), .PORT_STAT(port_stat), .SUPPLY_STAT(sup),
        .NET_STAT(net), .CH_IN(ch_in), .CH_FAULT(ch_fault), .PORT_LINK_LED(link_led),
        .PORT_ACTIVITY_LED(act_led), .RDY_LED(rdy_led), .NET_LED(net_led), .MOD_LED(mod_led),
        .SENSOR_SUPPLY_LED(us_led), .ACTUATOR_SUPPLY_LED(ua_led), .IO_CHANNELS(io_ch), .CH_OUT(ch_out),
        .IP_SUPPRESS(ip_sup));
    sid_panel i_sid_panel_rdy (.clk(clk), .clr(clr), .led(rdy_led), .seen(seen[3]));
    sid_panel i_sid_panel_net (.clk(clk), .clr(clr), .led(net_led), .seen(seen[2]));
    sid_panel i_sid_panel_mod (.clk(clk), .clr(clr), .led(mod_led), .seen(seen[1]));
    sid_panel i_sid_panel_us (.clk(clk), .clr(clr), .led(us_led), .seen(seen[0]));
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        checked++;
        if (got !== exp) begin
            bad_count++;
            $display("MISMATCH t=%0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask
    task automatic ahb(input logic wr, input logic [31:0] a, input logic [31:0] d);
        @(posedge clk);
        hsel <= 1'b1;
        haddr <= a;
        htrans <= 2'h2;
        hwrite <= wr;
        hsize <= 3'h2;
        do @(posedge clk); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge clk); while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask
    task results;
        $display("Counts: checked %0d, mismatches %0d", checked, bad_count);
        if (bad_count == 0 && checked > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    initial begin
        forever #2.5 clk = ~clk;
    end
    initial begin
        repeat (3000) @(posedge clk);
        bad_count++;
        results();
    end
    initial begin
        // Control, supply, network, then seen masks for ready, network, module, sensor supply.
        tbl = '{{8'h00, 6'h24, 5'h10, 16'h1112}, {8'h09, 6'h24, 5'h10, 16'h2222}, {8'h0B, 6'h24, 5'h10, 16'h5222},
            {8'h09, 6'h34, 5'h10, 16'h6222}, {8'h09, 6'h26, 5'h10, 16'h6222}, {8'h09, 6'h25, 5'h10, 16'h8222},
            {8'h09, 6'h24, 5'h04, 16'h2322}, {8'h09, 6'h24, 5'h02, 16'h2822}, {8'h09, 6'h24, 5'h03, 16'h2822},
            {8'h09, 6'h24, 5'h08, 16'h2922}, {8'h01, 6'h24, 5'h10, 16'h2232}, {8'h19, 6'h24, 5'h10, 16'h2282},
            {8'h29, 6'h24, 5'h10, 16'h2292}, {8'h0D, 6'h24, 5'h08, 16'h2AA2}, {8'h09, 6'h2C, 5'h10, 16'h6228},
            {8'h09, 6'h00, 5'h10, 16'h2221}};
        repeat (12) @(posedge clk);
        rst_n <= 1'b1;
        for (int i = 0; i < 4; i++) begin
            ahb(1'b0, 32'(4 * i), 32'h0);
            chk(rd, 32'h0, "reset value");
        end
        ahb(1'b1, 32'h20, 32'hFFFF_FFFF);
        ahb(1'b0, 32'h20, 32'h0);
        chk(rd, 32'h0, "unmapped");
        ahb(1'b1, 32'h04, 32'h0000_003C);
        ahb(1'b0, 32'h04, 32'h0);
        chk(rd, 32'h0000_003C, "substitute value");
        ahb(1'b1, 32'h104, 32'hFFFF_FFFF);
        ahb(1'b0, 32'h04, 32'h0);
        chk(rd, 32'h0000_003C, "page alias");
        port_stat <= 4'h9;
        repeat (3) @(posedge clk);
        chk(32'({link_led, act_led}), 32'h9, "port LEDs");
        ahb(1'b0, 32'h10, 32'h0);
        chk(rd, 32'h0000_0900, "status word");
        ahb(1'b0, 32'h14, 32'h0);
        chk(rd, 32'h0000_0006, "LED word");
        $display("done: registers and ports");
        for (int r = 0; r < 16; r++) begin
            ahb(1'b1, 32'h0, {24'h0, tbl[r][34:27]});
            sup <= tbl[r][26:21];
            net <= tbl[r][20:16];
            repeat (3) @(posedge clk);
            clr <= 1'b1;
            @(posedge clk);
            clr <= 1'b0;
            repeat (24) @(posedge clk);
            for (int k = 0; k < 4; k++) begin
                if (tbl[r][4*k+:4] != 4'h0) chk(32'(seen[k]), 32'(tbl[r][4*k+:4]), "pattern");
            end
            chk(32'({ua_led, ip_sup}), 32'({tbl[r][23], &tbl[r][17:16]}), "ua and address");
        end
        $display("done: indicator patterns");
        ahb(1'b1, 32'h08, 32'h0000_00FF);
        ahb(1'b1, 32'h0C, 32'h0000_00F5);
        ch_in <= 16'hA5A5;
        ch_fault <= 16'h0003;
        repeat (3) @(posedge clk);
        for (int i = 0; i < 16; i++) begin
            e = (i > 7) ? {ch_in[i], 1'b0} : (ch_fault[i] ? 2'h3 : {1'(16'h00F5 >> i), 1'b0});
            chk(32'(io_ch[2*i+:2]), 32'(e), "channel LED");
        end
        chk(32'(ch_out & 16'h00FF), 32'h0000_00F5, "drive");
        net <= 5'h08;
        repeat (3) @(posedge clk);
        chk(32'(ch_out & 16'h00FF), 32'h0000_003C, "safe state");
        net <= 5'h00;
        repeat (3) @(posedge clk);
        chk(32'(ch_out & 16'h00FF), 32'h0000_003C, "safe state held");
        ahb(1'b0, 32'h10, 32'h0);
        chk(rd, 32'h0000_0980, "timeout latched");
        net <= 5'h10;
        repeat (3) @(posedge clk);
        chk(32'(ch_out & 16'h00FF), 32'h0000_00F5, "recovered");
        $display("done: channels");
        results();
    end
endmodule
`default_nettype wire
